// file: pipm_channel.sv
// Purpose: One pin channel: synchroniser, edge detect and interrupt request.
// Assumes: Pin level is asynchronous to ref_clk_i.
// Notes: Edge flags are sticky until cleared; a new edge wins over a clear.
module pipm_channel (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    input wire logic level_mode_i,
    input wire logic rise_en_i,
    input wire logic fall_en_i,
    input wire logic clr_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o,
    output logic req_o
);
    logic sync1;
    logic sync2;
    logic prev;
    logic rise_flag;
    logic fall_flag;
    logic next_rise_flag;
    logic next_fall_flag;
    logic rise_now;
    logic fall_now;

    always_comb
    begin
        rise_now = sync2 & ~prev;
        fall_now = ~sync2 & prev;
        next_rise_flag = rise_now | (rise_flag & ~clr_i);
        next_fall_flag = fall_now | (fall_flag & ~clr_i);
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev <= 1'b0;
            rise_flag <= 1'b0;
            fall_flag <= 1'b0;
        end
        else
        begin
            sync1 <= pin_i;
            sync2 <= sync1;
            prev <= sync2;
            rise_flag <= next_rise_flag;
            fall_flag <= next_fall_flag;
        end
    end

    assign level_o = sync2;
    assign rise_o = rise_now;
    assign fall_o = fall_now;
    assign req_o = level_mode_i ? (sync2 == rise_en_i)
                                : ((rise_flag & rise_en_i) | (fall_flag & fall_en_i));
endmodule

// file: pipm_engine.sv
// Purpose: Pin interrupt and pattern match engine with plain control ports.
// Assumes: Single clock ref_clk_i at 250 MHz; pins asynchronous.
// Notes: Control ports settle from a fast single-cycle register block.
module pipm_engine (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [pipm_pkg::PIPM_PINS-1:0] pins_i,
    input wire logic [pipm_pkg::PIPM_CHANNELS*pipm_pkg::PIPM_SEL_W-1:0] pin_sel_i,
    input wire logic [pipm_pkg::PIPM_CHANNELS-1:0] level_mode_i,
    input wire logic [pipm_pkg::PIPM_CHANNELS-1:0] rise_en_i,
    input wire logic [pipm_pkg::PIPM_CHANNELS-1:0] fall_en_i,
    input wire logic [pipm_pkg::PIPM_CHANNELS-1:0] clr_i,
    input wire logic pattern_mode_i,
    input wire logic [pipm_pkg::PIPM_CHANNELS*3-1:0] slice_cond_i,
    input wire logic [pipm_pkg::PIPM_CHANNELS*3-1:0] slice_src_i,
    input wire logic [pipm_pkg::PIPM_CHANNELS-1:0] slice_end_i,
    input wire logic event_en_i,
    input wire logic deep_sleep_i,
    output logic [pipm_pkg::PIPM_CHANNELS-1:0] irq_o,
    output logic [pipm_pkg::PIPM_CHANNELS-1:0] wake_o,
    output logic [pipm_pkg::PIPM_CHANNELS-1:0] level_o,
    output logic cpu_receive_event_o,
    output logic event_pin_o
);
    localparam int N = pipm_pkg::PIPM_CHANNELS;
    localparam int W = pipm_pkg::PIPM_SEL_W;

    logic [N-1:0] sel_pin;
    logic [N-1:0] ch_level;
    logic [N-1:0] ch_rise;
    logic [N-1:0] ch_fall;
    logic [N-1:0] ch_req;
    logic [N-1:0] ch_clr;
    logic [N-1:0] st_rise;
    logic [N-1:0] st_fall;
    logic [N-1:0] next_st_rise;
    logic [N-1:0] next_st_fall;
    logic [N-1:0] slice_val;
    logic [N-1:0] term_hit;
    logic [N-1:0] term_prev;
    logic [N-1:0] next_irq;
    logic [N-1:0] next_wake;
    logic next_event;
    logic any_match;

    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            sel_pin[i] = pins_i[pin_sel_i[i*W +: W]];
        end
    end

    for (genvar g = 0; g < N; g++)
    begin : g_ch
        pipm_channel u_ch (
            .ref_clk_i(ref_clk_i),
            .rst_i(rst_i),
            .pin_i(sel_pin[g]),
            .level_mode_i(level_mode_i[g]),
            .rise_en_i(rise_en_i[g]),
            .fall_en_i(fall_en_i[g]),
            .clr_i(ch_clr[g]),
            .level_o(ch_level[g]),
            .rise_o(ch_rise[g]),
            .fall_o(ch_fall[g]),
            .req_o(ch_req[g])
        );
    end

    assign ch_clr = clr_i & {N{~pattern_mode_i}};

    always_comb
    begin
        logic [2:0] src;
        logic [2:0] cond;
        logic acc;
        src = 3'h0;
        cond = 3'h0;
        acc = 1'b1;
        next_st_rise = (st_rise | ch_rise) & ~clr_i;
        next_st_fall = (st_fall | ch_fall) & ~clr_i;
        // Hardware edges win over a simultaneous clear.
        next_st_rise = next_st_rise | ch_rise;
        next_st_fall = next_st_fall | ch_fall;
        for (int i = 0; i < N; i++)
        begin
            src = slice_src_i[i*3 +: 3];
            cond = slice_cond_i[i*3 +: 3];
            unique case (cond)
                pipm_pkg::PIPM_COND_CONST_HI: slice_val[i] = 1'b1;
                pipm_pkg::PIPM_COND_RISE_STICKY: slice_val[i] = st_rise[src];
                pipm_pkg::PIPM_COND_FALL_STICKY: slice_val[i] = st_fall[src];
                pipm_pkg::PIPM_COND_EDGE_STICKY:
                    slice_val[i] = st_rise[src] | st_fall[src];
                pipm_pkg::PIPM_COND_HIGH: slice_val[i] = ch_level[src];
                pipm_pkg::PIPM_COND_LOW: slice_val[i] = ~ch_level[src];
                pipm_pkg::PIPM_COND_CONST_LO: slice_val[i] = 1'b0;
                pipm_pkg::PIPM_COND_EVENT: slice_val[i] = ch_rise[src] | ch_fall[src];
            endcase
        end
        // product terms over the selected pins
        for (int i = 0; i < N; i++)
        begin
            acc = acc & slice_val[i];
            term_hit[i] = slice_end_i[i] & acc;
            if (slice_end_i[i])
            begin
                acc = 1'b1;
            end
        end
    end

    always_comb
    begin
        any_match = |term_hit;
        if (pattern_mode_i)
        begin
            next_irq = term_hit & ~term_prev;
            next_wake = next_irq & {N{~deep_sleep_i}};
        end
        else
        begin
            next_irq = ch_req;
            // channel wake in sleep and deep-sleep
            next_wake = ch_req;
        end
        next_event = pattern_mode_i & event_en_i & any_match & ~(|term_prev);
    end

    // controls act on the next edge
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_rise <= '0;
            st_fall <= '0;
            term_prev <= '0;
            irq_o <= '0;
            wake_o <= '0;
            level_o <= '0;
            cpu_receive_event_o <= 1'b0;
            event_pin_o <= 1'b0;
        end
        else
        begin
            st_rise <= next_st_rise;
            st_fall <= next_st_fall;
            term_prev <= term_hit;
            irq_o <= next_irq;
            wake_o <= next_wake;
            level_o <= ch_level;
            cpu_receive_event_o <= next_event;
            event_pin_o <= next_event;
        end
    end
endmodule

// file: pipm_pin_model.sv
// Purpose: External pins seen by the engine.
// Assumes: One pin moves at a time, launched at a rising edge.
// Notes: Pins come up low, as from an idle source.
module pipm_pin_model (
    input wire logic ref_clk_i,
    output logic [63:0] pins_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pins_o = 64'h0;
    task automatic drive(input logic [5:0] idx, input logic lvl);
        @(posedge ref_clk_i);
        pins_o[idx] <= lvl;
    endtask
endmodule

// file: pipm_pkg.sv
// Purpose: Shared constants for the pin interrupt and pattern match engine.
// Assumes: Eight channels, 64 selectable pins from ports 0 and 1.
// Notes: Mode and slice condition encodings are local to this block.
package pipm_pkg;
    localparam int PIPM_CHANNELS = 8;
    localparam int PIPM_PINS = 64;
    localparam int PIPM_SEL_W = 6;
    localparam logic [PIPM_SEL_W-1:0] PIPM_SEL_RESET = 6'h00;
    localparam logic [2:0] PIPM_COND_CONST_HI = 3'h0;
    localparam logic [2:0] PIPM_COND_RISE_STICKY = 3'h1;
    localparam logic [2:0] PIPM_COND_FALL_STICKY = 3'h2;
    localparam logic [2:0] PIPM_COND_EDGE_STICKY = 3'h3;
    localparam logic [2:0] PIPM_COND_HIGH = 3'h4;
    localparam logic [2:0] PIPM_COND_LOW = 3'h5;
    localparam logic [2:0] PIPM_COND_CONST_LO = 3'h6;
    localparam logic [2:0] PIPM_COND_EVENT = 3'h7;
    localparam logic [2:0] PIPM_COND_RESET = 3'h0;
endpackage

// file: pipm_properties.sv
// Purpose: Port assertions for channel 0, slice 0, all eight wake outputs and the event outputs of the pin engine.
// Assumes: Controls move only while channel 0 is quiet.
// Notes: Bound to the engine from the bench top file.
module pipm_properties (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [63:0] pins_i,
    input wire logic [47:0] pin_sel_i,
    input wire logic [7:0] level_mode_i,
    input wire logic [7:0] rise_en_i,
    input wire logic [7:0] fall_en_i,
    input wire logic [7:0] clr_i,
    input wire logic pattern_mode_i,
    input wire logic event_en_i,
    input wire logic deep_sleep_i,
    input wire logic [7:0] irq_o,
    input wire logic [7:0] wake_o,
    input wire logic cpu_receive_event_o,
    input wire logic event_pin_o
);
    logic p0;
    logic em;
    assign p0 = pins_i[pin_sel_i[5:0]];
    assign em = !level_mode_i[0] && !pattern_mode_i;
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_edge;
        ($rose(p0) && rise_en_i[0]) || ($fell(p0) && fall_en_i[0]);
    endsequence
    a_edge_irq: assert property (
        em ##0 s_edge |-> ##4 irq_o[0]) else $error("edge missed");
    a_flag_hold: assert property (
        em && irq_o[0] && !clr_i[0] && !$past(clr_i[0]) && !$past(pattern_mode_i)
        |=> irq_o[0]) else $error("flag dropped");
    a_clr_drop: assert property (
        em && clr_i[0] && $stable(p0) && p0 == $past(p0, 4) |-> ##2 !irq_o[0])
        else $error("clear ignored");
    a_level_follow: assert property (
        (level_mode_i[0] && !pattern_mode_i && $stable(p0) && $stable(rise_en_i[0])) [*4]
        |-> irq_o[0] == (p0 ~^ rise_en_i[0])) else $error("level wrong");
    a_event_pulse: assert property (
        cpu_receive_event_o |-> $past(event_en_i) ##1 !cpu_receive_event_o)
        else $error("event wrong");
    a_event_pin: assert property (
        event_pin_o == cpu_receive_event_o) else $error("event pin differs");
    a_wake_gate: assert property (
        wake_o == (($past(pattern_mode_i) && $past(deep_sleep_i)) ? 8'h00 : irq_o))
        else $error("wake wrong");
    a_term_pulse: assert property (
        pattern_mode_i && $past(pattern_mode_i) && irq_o[0] |=> !irq_o[0])
        else $error("term not a pulse");
endmodule

// file: tb_top.sv
// Purpose: Self-checking bench for the pin interrupt engine.
// Assumes: Channel 0 and slice 0 watch port 1 pin 5.
// Notes: Deep sleep stays set so wake gating is seen.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [5:0] PIN = 6'h25;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [63:0] pins;
    logic [7:0] lvl = 8'h00, rise = 8'h00, fall = 8'h00, clr = 8'h00, irq, wake;
    logic pat = 1'b0, ev = 1'b0, deep = 1'b1, evc, evp;
    logic [23:0] cond = {21'h0, pipm_pkg::PIPM_COND_HIGH};
    logic [7:0] lvo;
    int n_fail = 0, comparisons = 0, cycles = 0;
    pipm_pin_model pipm_pin_model_i (.ref_clk_i(ref_clk_i), .pins_o(pins));
    pipm_engine pipm_engine_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .pins_i(pins),
        .pin_sel_i({42'h0, PIN}), .level_mode_i(lvl), .rise_en_i(rise), .fall_en_i(fall),
        .clr_i(clr), .pattern_mode_i(pat), .slice_cond_i(cond),
        .slice_src_i(24'h0), .slice_end_i(8'h01), .event_en_i(ev), .deep_sleep_i(deep),
        .irq_o(irq), .wake_o(wake), .level_o(lvo), .cpu_receive_event_o(evc), .event_pin_o(evp));
    always #2 ref_clk_i = ~ref_clk_i;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic pulse_clr;
        @(posedge ref_clk_i);
        clr <= 8'h01;
        @(posedge ref_clk_i);
        clr <= 8'h00;
        wait_cyc(4);
    endtask
    task automatic t_edge;
        for (int m = 1; m < 4; m++)
        begin
            @(posedge ref_clk_i);
            rise <= {7'h0, m[0]};
            fall <= {7'h0, m[1]};
            pulse_clr();
            pipm_pin_model_i.drive(PIN, 1'b1);
            wait_cyc(6);
            check(irq, {7'h0, m[0]});
            // deep sleep held, wake path stands enabled.
            check(wake, {7'h0, m[0]});
            pulse_clr();
            pipm_pin_model_i.drive(PIN, 1'b0);
            wait_cyc(6);
            check(irq, {7'h0, m[1]});
        end
        $display("edge test done");
    endtask
    task automatic t_level;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge ref_clk_i);
            lvl <= 8'h01;
            rise <= {7'h0, i[1]};
            pipm_pin_model_i.drive(PIN, i[0]);
            wait_cyc(6);
            check(irq, {7'h0, i[0] ~^ i[1]});
            check(lvo, {7'h0, i[0]});
        end
        $display("level test done");
    endtask
    task automatic t_pattern;
        int hits;
        int evs;
        int evps;
        hits = 0;
        evs = 0;
        evps = 0;
        pipm_pin_model_i.drive(PIN, 1'b0);
        pat <= 1'b1;
        ev <= 1'b1;
        pulse_clr();
        pipm_pin_model_i.drive(PIN, 1'b1);
        repeat (10)
        begin
            wait_cyc(1);
            hits += irq[0];
            evs += evc;
            evps += evp;
            check(wake, 8'h00);
        end
        check(hits[7:0], 8'h01);
        check(evs[7:0], 8'h01);
        check(evps[7:0], 8'h01);
        $display("pattern test done");
    endtask
    task automatic t_sticky;
        int hits;
        hits = 0;
        @(posedge ref_clk_i);
        cond <= {21'h0, pipm_pkg::PIPM_COND_RISE_STICKY};
        pipm_pin_model_i.drive(PIN, 1'b0);
        pulse_clr();
        pipm_pin_model_i.drive(PIN, 1'b1);
        repeat (10)
        begin
            wait_cyc(1);
            hits += irq[0];
        end
        check(hits[7:0], 8'h01);
        pulse_clr();
        check(irq, 8'h00);
        $display("sticky test done");
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge ref_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            n_fail++;
            complete_run();
        end
    end
    initial
    begin
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        wait_cyc(4);
        t_edge();
        t_level();
        t_pattern();
        t_sticky();
        complete_run();
    end
endmodule
bind pipm_engine pipm_properties pipm_properties_i (.*);
